// File: src/pdslc_pkg.sv
// Purpose: Shared constants for the port device status / link capability register bank
// Assumes: Byte addresses on the register port, 32-bit data, narrower registers in low bits
// Notes:   Interrupt status and mask registers sit beside the status and capability registers
package pdslc_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  localparam logic [11:0] DSTS_OFFS     = 12'h04a;
  localparam logic [11:0] LCAP_OFFS     = 12'h04c;
  localparam logic [11:0] IRQ_STAT_OFFS = 12'h100;
  localparam logic [11:0] IRQ_MASK_OFFS = 12'h104;

  // Device status layout
  localparam int          ERR_W            = 4;
  localparam int          CORR_BIT         = 0;
  localparam int          NONFATAL_BIT     = 1;
  localparam int          FATAL_BIT        = 2;
  localparam int          UNSUP_BIT        = 3;
  localparam int          AUX_POWER_BIT    = 4;
  localparam int          PENDING_BIT      = 5;
  localparam int          DSTS_W           = 16;
  localparam logic [3:0]  ERR_RESET        = 4'h0;
  localparam logic        AUX_POWER_VAL    = 1'b0;
  localparam logic        PENDING_VAL      = 1'b0;

  // Link capabilities layout
  localparam int          SPEED_LSB        = 0;
  localparam int          SPEED_W          = 4;
  localparam logic [3:0]  SPEED_VAL        = 4'h2;
  localparam int          LANES_LSB        = 4;
  localparam int          LANES_W          = 6;
  localparam int          ASPM_LSB         = 10;
  localparam int          ASPM_W           = 2;
  localparam logic [1:0]  ASPM_RESET       = 2'h3;
  localparam int          L0S_LSB          = 12;
  localparam int          L0S_W            = 3;
  localparam logic [2:0]  L0S_RESET        = 3'h6;
  localparam logic [5:0]  LANES_RESET      = 6'h00;

  // Interrupt status layout: four error classes plus retrain start
  localparam int          IRQ_W            = 5;
  localparam int          IRQ_RETRAIN_BIT  = 4;
  localparam logic [4:0]  IRQ_RESET        = 5'h00;

  function automatic logic isValidLanes(input logic [5:0] lanes);
    case (lanes)
      6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20: isValidLanes = 1'b1;
      default:                                         isValidLanes = 1'b0;
    endcase
  endfunction

endpackage

// File: src/pdslc_lcap_if.sv
// Purpose: Carrier between the register front end and the link capability fields
// Assumes: Single clock domain
// Notes:   capValue is the assembled register image
`timescale 1ns/100ps
interface pdslc_lcap_if;
  logic        wrEn;
  logic [31:0] wrData;
  logic [5:0]  hwLanes;
  logic        portDisabled;
  logic [31:0] capValue;
  logic [5:0]  activeLanes;
  logic        retrain;

  modport regs   (output wrEn, wrData, hwLanes, portDisabled,
                  input  capValue, activeLanes, retrain);
  modport fields (input  wrEn, wrData, hwLanes, portDisabled,
                  output capValue, activeLanes, retrain);
endinterface

// File: src/pdslc_lcap.sv
// Purpose: Link capability fields, lane-count override and retrain trigger
// Assumes: hwLanes strap is stable around reset release
// Notes:   Strap is caught on the first edge after release, never under reset
`timescale 1ns/100ps
module pdslc_lcap (
  input wire logic clk,
  input wire logic reset_n,
  pdslc_lcap_if.fields lc
);

  typedef struct packed {
    logic       initDone;
    logic [5:0] initLanes;
    logic [5:0] laneField;
    logic [1:0] aspm;
    logic [2:0] l0sLat;
    logic [5:0] activeLanes;
    logic       retrain;
  } pdslc_lcap_state_t;

  pdslc_lcap_state_t s_r;
  pdslc_lcap_state_t s_nxt;
  logic [5:0]        wrLanes;

  assign wrLanes = lc.wrData[pdslc_pkg::LANES_LSB +: pdslc_pkg::LANES_W];

  always_comb begin
    s_nxt         = s_r;
    s_nxt.retrain = 1'b0;
    if (!s_r.initDone) begin
      s_nxt.initDone    = 1'b1;
      s_nxt.initLanes   = lc.hwLanes;
      s_nxt.laneField   = lc.hwLanes;
      s_nxt.activeLanes = lc.hwLanes;
    end else if (lc.wrEn) begin
      // Only the overridable fields take write data; the rest is hardwired
      s_nxt.laneField = wrLanes;
      s_nxt.aspm      = lc.wrData[pdslc_pkg::ASPM_LSB +: pdslc_pkg::ASPM_W];
      s_nxt.l0sLat    = lc.wrData[pdslc_pkg::L0S_LSB +: pdslc_pkg::L0S_W];
      // Reserved codes fall back quietly; a larger legal code is trusted as is
      s_nxt.activeLanes = pdslc_pkg::isValidLanes(wrLanes) ? wrLanes : s_r.initLanes;
      s_nxt.retrain     = !lc.portDisabled;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{initDone: 1'b0, initLanes: pdslc_pkg::LANES_RESET,
               laneField: pdslc_pkg::LANES_RESET, aspm: pdslc_pkg::ASPM_RESET,
               l0sLat: pdslc_pkg::L0S_RESET, activeLanes: pdslc_pkg::LANES_RESET,
               retrain: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    lc.capValue = '0;
    lc.capValue[pdslc_pkg::SPEED_LSB +: pdslc_pkg::SPEED_W] = pdslc_pkg::SPEED_VAL;
    lc.capValue[pdslc_pkg::LANES_LSB +: pdslc_pkg::LANES_W] = s_r.laneField;
    lc.capValue[pdslc_pkg::ASPM_LSB +: pdslc_pkg::ASPM_W]   = s_r.aspm;
    lc.capValue[pdslc_pkg::L0S_LSB +: pdslc_pkg::L0S_W]     = s_r.l0sLat;
  end

  assign lc.activeLanes = s_r.activeLanes;
  assign lc.retrain     = s_r.retrain;

endmodule // pdslc_lcap

// File: src/pdslc_top.sv
// Purpose: Device status and link capability registers for one switch port
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Error detect inputs are one-cycle pulses from the error logic
//
// How it works
// - Error pulses set status flags regardless of enables
// - Flags reset zero, sticky, write-one clears
// - Aux power bit reads zero
// - Pending bit and bits 15:6 read zero
// - Link speed field hardwired to 5 Gbps
// - Lane count field loads strap value
// - Reserved lane code uses initial width
// - Written lane code read back unchanged
// - Lane write outside disabled starts retrain
// - Power state support defaults both, writable
// - Standby exit latency defaults to six
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module pdslc_top #(
  parameter int ADDR_W = pdslc_pkg::ADDR_W
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [31:0]       wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [31:0]       rdData,
  input  wire logic              errCorrectable,
  input  wire logic              errNonfatal,
  input  wire logic              errFatal,
  input  wire logic              errUnsupported,
  input  wire logic              portDisabled,
  input  wire logic [5:0]        hwLaneCount,
  output logic      [5:0]        activeLaneCount,
  output logic                   retrainReq,
  output logic                   irq
);

  // Offsets decode on twelve bits; a wider port would alias them
  if (ADDR_W < 9 || ADDR_W > 12) begin : g_addrCheck
    $error("ADDR_W must lie between 9 and 12");
  end

  typedef struct packed {
    logic [3:0]  errSeen;
    logic [4:0]  irqStat;
    logic [4:0]  irqMask;
    logic [31:0] rdData;
    logic        irq;
  } pdslc_top_state_t;

  pdslc_top_state_t s_r;
  pdslc_top_state_t s_nxt;
  pdslc_lcap_if     lcBus ();

  logic [3:0]  errEvents;
  logic [11:0] addrW;
  logic        hitDsts;
  logic        hitLcap;
  logic        hitStat;
  logic        hitMask;

  assign addrW     = 12'(addr);
  assign errEvents = {errUnsupported, errFatal, errNonfatal, errCorrectable};
  assign hitDsts   = addrW == pdslc_pkg::DSTS_OFFS;
  assign hitLcap   = addrW == pdslc_pkg::LCAP_OFFS;
  assign hitStat   = addrW == pdslc_pkg::IRQ_STAT_OFFS;
  assign hitMask   = addrW == pdslc_pkg::IRQ_MASK_OFFS;

  assign lcBus.wrEn         = wrStb && hitLcap;
  assign lcBus.wrData       = wrData;
  assign lcBus.hwLanes      = hwLaneCount;
  assign lcBus.portDisabled = portDisabled;

  pdslc_lcap u_lcap (
    .clk     (clk),
    .reset_n (reset_n),
    .lc      (lcBus)
  );

  function automatic logic [31:0] devStatus(input logic [3:0] flags);
    devStatus = '0;
    devStatus[pdslc_pkg::ERR_W-1:0]        = flags;
    devStatus[pdslc_pkg::AUX_POWER_BIT]    = pdslc_pkg::AUX_POWER_VAL;
    devStatus[pdslc_pkg::PENDING_BIT]      = pdslc_pkg::PENDING_VAL;
  endfunction

  always_comb begin
    logic [3:0] clr;
    logic [4:0] irqEvents;
    clr       = '0;
    irqEvents = '0;
    s_nxt     = s_r;
    if (wrStb && hitDsts) begin
      clr = wrData[pdslc_pkg::ERR_W-1:0];
    end
    // Set wins over clear so an error in the clearing cycle is kept
    s_nxt.errSeen = (s_r.errSeen & ~clr) | errEvents;
    irqEvents = {lcBus.retrain, errEvents};
    if (rdStb && hitStat) begin
      s_nxt.irqStat = irqEvents;
    end else begin
      s_nxt.irqStat = s_r.irqStat | irqEvents;
    end
    if (wrStb && hitMask) begin
      s_nxt.irqMask = wrData[pdslc_pkg::IRQ_W-1:0];
    end
    s_nxt.irq    = |(s_nxt.irqStat & s_nxt.irqMask);
    s_nxt.rdData = '0;
    if (rdStb) begin
      unique case (1'b1)
        hitDsts: s_nxt.rdData = devStatus(s_r.errSeen);
        hitLcap: s_nxt.rdData = lcBus.capValue;
        hitStat: s_nxt.rdData = 32'(s_r.irqStat);
        hitMask: s_nxt.rdData = 32'(s_r.irqMask);
        default: s_nxt.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '{errSeen: pdslc_pkg::ERR_RESET, irqStat: pdslc_pkg::IRQ_RESET,
               irqMask: pdslc_pkg::IRQ_RESET, rdData: 32'h00000000, irq: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdData          = s_r.rdData;
  assign irq             = s_r.irq;
  assign activeLaneCount = lcBus.activeLanes;
  assign retrainReq      = lcBus.retrain;

endmodule // pdslc_top

// File: verification/pdslc_top_assertions.sv
// Purpose: Port-level checks of the status and link capability bank
// Assumes: Strap input held steady while running
// Notes:   Read data judged in the cycle after the strobe
`timescale 1ns/100ps
module pdslc_top_assertions #(
  parameter int ADDR_W = pdslc_pkg::ADDR_W
) (
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [31:0]       wrData,
  input wire logic              wrStb,
  input wire logic              rdStb,
  input wire logic [31:0]       rdData,
  input wire logic              errCorrectable,
  input wire logic              errNonfatal,
  input wire logic              errFatal,
  input wire logic              errUnsupported,
  input wire logic              portDisabled,
  input wire logic [5:0]        hwLaneCount,
  input wire logic [5:0]        activeLaneCount,
  input wire logic              retrainReq,
  input wire logic              irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  logic [3:0] errs;
  logic       dsRd;
  logic       lcRd;
  logic       lcWr;
  logic       legal;
  assign errs = {errUnsupported, errFatal, errNonfatal, errCorrectable};
  assign dsRd = rdStb && addr == pdslc_pkg::DSTS_OFFS;
  assign lcRd = rdStb && addr == pdslc_pkg::LCAP_OFFS;
  assign lcWr = wrStb && addr == pdslc_pkg::LCAP_OFFS;
  assign legal = wrData[9:4] inside {6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
  a_aux_zero: assert property (dsRd |=> !rdData[4]) else $error("aux bit set");
  a_status_upper: assert property (dsRd |=> rdData[31:5] == 27'h0) else $error("status hi");
  a_speed_fixed: assert property (lcRd |=> rdData[3:0] == 4'h2) else $error("speed");
  a_error_logged: assert property ((errs != 4'h0) ##1 dsRd |=>
    (rdData[3:0] & $past(errs, 2)) == $past(errs, 2)) else $error("error lost");
  // Back-to-back reads leave no slot for a clearing write
  a_flag_sticky: assert property (dsRd ##1 dsRd |=>
    (rdData[3:0] & $past(rdData[3:0])) == $past(rdData[3:0])) else $error("flag lost");
  a_retrain_gated: assert property ((lcWr && !portDisabled) |=> retrainReq
    ) else $error("no retrain");
  a_lane_follows: assert property (lcWr && legal |=> activeLaneCount == $past(wrData[9:4])
    ) else $error("lane count");
  a_lane_fallback: assert property (lcWr && !legal |=> activeLaneCount == $past(hwLaneCount)
    ) else $error("lane fallback");
  cover property (lcWr && !portDisabled);
  cover property (lcWr && portDisabled);
  cover property (dsRd ##1 dsRd);
  cover property ((errs != 4'h0) ##1 dsRd);
endmodule // pdslc_top_assertions
bind pdslc_top pdslc_top_assertions #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .reset_n(reset_n),
  .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .errCorrectable(errCorrectable), .errNonfatal(errNonfatal), .errFatal(errFatal),
  .errUnsupported(errUnsupported), .portDisabled(portDisabled), .hwLaneCount(hwLaneCount),
  .activeLaneCount(activeLaneCount), .retrainReq(retrainReq), .irq(irq));

// File: verification/testbench.sv
// Purpose: Register-level bench for the status and link capability bank
// Assumes: Strap fixed at thirty-two lanes, so no legal write widens
// Notes:   Outputs sampled 1 ns after the edge that took a request
`timescale 1ns/100ps
module testbench;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wrData = 32'h0;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic [3:0]  errs = 4'h0;
  logic        portDisabled = 1'b0;
  logic [5:0]  hwLaneCount = 6'h20;
  logic [31:0] rdData;
  logic [5:0]  activeLaneCount;
  logic        retrainReq;
  logic        irq;
  int          error_cnt = 0;
  int          checks_done = 0;
  logic [5:0]  codes [10] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20, 6'h00, 6'h03, 6'h3f};
  always #12.5 clk = ~clk;
  pdslc_top i_dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .errCorrectable(errs[0]), .errNonfatal(errs[1]),
    .errFatal(errs[2]), .errUnsupported(errs[3]), .portDisabled(portDisabled),
    .hwLaneCount(hwLaneCount), .activeLaneCount(activeLaneCount), .retrainReq(retrainReq),
    .irq(irq));
  task automatic test_done;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask
  task automatic pulse(input logic [3:0] e);
    @(posedge clk);
    errs <= e;
    @(posedge clk);
    errs <= 4'h0;
    #1;
  endtask
  initial begin
    #50000;
    error_cnt++;
    test_done;
  end
  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(pdslc_pkg::DSTS_OFFS, 32'h0);
    rd(pdslc_pkg::LCAP_OFFS, 32'h6e02);
    rd(12'h200, 32'h0);
    wr(pdslc_pkg::IRQ_MASK_OFFS, 32'h1f);
    pulse(4'hf);
    chk({31'h0, irq}, 32'h1);
    rd(pdslc_pkg::DSTS_OFFS, 32'hf);
    wr(pdslc_pkg::DSTS_OFFS, 32'h0);
    rd(pdslc_pkg::DSTS_OFFS, 32'hf);
    wr(pdslc_pkg::DSTS_OFFS, 32'h5);
    rd(pdslc_pkg::DSTS_OFFS, 32'ha);
    wr(pdslc_pkg::DSTS_OFFS, 32'hffff_ffff);
    rd(pdslc_pkg::DSTS_OFFS, 32'h0);
    rd(pdslc_pkg::IRQ_STAT_OFFS, 32'hf);
    rd(pdslc_pkg::IRQ_STAT_OFFS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(pdslc_pkg::IRQ_MASK_OFFS, 32'h0);
    pulse(4'h2);
    chk({31'h0, irq}, 32'h0);
    wr(pdslc_pkg::IRQ_MASK_OFFS, 32'h1f);
    chk({31'h0, irq}, 32'h1);
    rd(pdslc_pkg::IRQ_STAT_OFFS, 32'h2);
    // Error arriving with a read, then a second read with no gap
    @(posedge clk);
    errs <= 4'h8;
    addr <= pdslc_pkg::DSTS_OFFS;
    rdStb <= 1'b1;
    @(posedge clk);
    errs <= 4'h0;
    #1;
    chk(rdData, 32'h2);
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    chk(rdData, 32'ha);
    rd(pdslc_pkg::IRQ_STAT_OFFS, 32'h8);
    // Read-only bits written as ones must not stick; no legal code exceeds the strap
    foreach (codes[i]) begin
      wr(pdslc_pkg::LCAP_OFFS, {17'h1ffff, 3'h2, 2'h1, codes[i], 4'hf});
      chk({31'h0, retrainReq}, 32'h1);
      chk({26'h0, activeLaneCount}, {26'h0, (i < 7) ? codes[i] : 6'h20});
      rd(pdslc_pkg::LCAP_OFFS, {17'h0, 3'h2, 2'h1, codes[i], 4'h2});
      chk({31'h0, retrainReq}, 32'h0);
    end
    @(posedge clk);
    portDisabled <= 1'b1;
    wr(pdslc_pkg::LCAP_OFFS, 32'h0000_6c42);
    chk({31'h0, retrainReq}, 32'h0);
    chk({26'h0, activeLaneCount}, 32'h4);
    rd(pdslc_pkg::IRQ_STAT_OFFS, 32'h10);
    chk({31'h0, irq}, 32'h0);
    test_done;
  end
endmodule // testbench
